//--- adc_cfg_pkg.sv
// constants and carrier types of the converter input configuration register
// assumes a classic wishbone slave port and a single 250 MHz clock
package adc_cfg_pkg;

    // ************************************************************
    // address map
    // ************************************************************
    localparam int ADR_W = 16;
    localparam logic [ADR_W-1:0] CFG_ADDR = 16'h21a8;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    // bits that hold state; all others read zero
    localparam logic [31:0] CFG_RW_MASK = 32'h0007_ff3f;

    // ************************************************************
    // field layout
    // ************************************************************
    localparam int GAIN_LSB = 16;
    localparam int GAIN_W = 3;
    localparam int OFFS_BIT = 15;
    localparam int RSV_LSB = 13;
    localparam int RSV_W = 2;
    localparam int NEG_LSB = 8;
    localparam int NEG_W = 5;
    localparam int POS_LSB = 0;
    localparam int POS_W = 6;

    // ************************************************************
    // gain codes and gain in halves (gain 1.5 -> 3)
    // ************************************************************
    localparam logic [2:0] GAIN_X1 = 3'h0;
    localparam logic [2:0] GAIN_X1P5 = 3'h1;
    localparam logic [2:0] GAIN_X2 = 3'h2;
    localparam logic [2:0] GAIN_X4 = 3'h3;
    localparam logic [2:0] GAIN_X9A = 3'h4;
    localparam logic [2:0] GAIN_X9B = 3'h5;
    localparam logic [4:0] HALVES_X1 = 5'h02;
    localparam logic [4:0] HALVES_X1P5 = 5'h03;
    localparam logic [4:0] HALVES_X2 = 5'h04;
    localparam logic [4:0] HALVES_X4 = 5'h08;
    localparam logic [4:0] HALVES_X9 = 5'h12;

    // ************************************************************
    // select code tables: one bit per defined code
    // ************************************************************
    localparam logic [31:0] NEG_VALID = 32'h0013_59f7;
    // positive code 17 is reserved, so bit 17 stays clear
    localparam logic [63:0] POS_VALID = 64'h0000_001a_efdd_fff7;
    localparam logic [NEG_W-1:0] NEG_TEMP_SENSOR = 5'h0b;
    localparam logic [NEG_W-1:0] NEG_EXCITE = 5'h14;
    localparam logic [POS_W-1:0] POS_CE_HALF = 6'h1f;
    localparam logic [POS_W-1:0] POS_EXCITE = 6'h24;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [GAIN_W-1:0] gain;
        logic offset_cancel;
        logic [RSV_W-1:0] spare;
        logic [NEG_W-1:0] neg;
        logic [POS_W-1:0] pos;
    } cfg_s;

    typedef struct packed {
        logic [4:0] gain_halves;
        logic gain_valid;
        logic gain_conflict;
    } gain_s;

endpackage

//--- adc_sel_decode.sv
// one-hot decoder for one converter input multiplexer
// assumes code is stable register content; output lags it by one clock
`timescale 1ns/1ps
module adc_sel_decode #(
    parameter int W = 5,
    parameter logic [(1<<W)-1:0] VALID = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // select code
    input wire logic [W-1:0] code,
    // switch enables, bit n closes the switch of code n
    output logic [(1<<W)-1:0] route_q,
    output logic reserved_q
);
    localparam int N = 1 << W;

    if (W < 1 || W > 6) begin : g_bad_width
        $error("adc_sel_decode: W out of range");
    end

    wire is_defined = VALID[code];
    // reserved codes close no switch, same as the floating code
    wire [N-1:0] route_d = (is_defined && code != '0) ?
        (N'(1) << code) : '0;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            route_q <= '0;
            reserved_q <= 1'b0;
        end else begin
            route_q <= route_d;
            reserved_q <= !is_defined;
        end
    end

    a_reserved_float: assert property (@(posedge clk) disable iff (!reset_n)
        !VALID[code] |=> route_q == '0 && reserved_q)
        else $error("reserved select code closed a switch");

    a_route_onehot: assert property (@(posedge clk)
        disable iff (!reset_n)
        (VALID[code] && code != '0) |=> route_q == (N'(1) << $past(code)))
        else $error("defined select code routed wrongly");
endmodule

//--- adc_input_config.sv
// converter input configuration register behind a classic wishbone slave
// assumes one clock, synchronous active-low reset, bus inputs synchronous
`timescale 1ns/1ps
module adc_input_config
    import adc_cfg_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [adc_cfg_pkg::ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // analog front end status in
    input wire logic AMP_ENABLE,
    // configuration out
    output adc_cfg_pkg::cfg_s CFG,
    output adc_cfg_pkg::gain_s GAIN,
    output logic [31:0] NEG_ROUTE,
    output logic NEG_RESERVED,
    output logic [63:0] POS_ROUTE,
    output logic POS_RESERVED
);
    import adc_cfg_pkg::*;

    // ************************************************************
    // bus decode
    // ************************************************************
    logic ack_q;
    logic [31:0] dat_q;
    cfg_s cfg_q;
    cfg_s cfg_d;
    gain_s gain_q;
    gain_s gain_d;

    wire req = WB_CYC_I && WB_STB_I && !ack_q;
    wire hit = WB_ADR_I[ADR_W-1:2] == CFG_ADDR[ADR_W-1:2];
    wire wr_hit = req && WB_WE_I && hit;
    wire rd_hit = req && !WB_WE_I && hit;

    // byte lanes: only lanes 0, 1 and 2 carry stored bits
    wire [31:0] lane_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                             {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    wire [31:0] wr_mask = lane_mask & CFG_RW_MASK;
    wire [31:0] cfg_word = {13'h0000, cfg_q.gain, cfg_q.offset_cancel,
                            cfg_q.spare, cfg_q.neg, 2'h0, cfg_q.pos};
    wire [31:0] new_word = (cfg_word & ~wr_mask) | (WB_DAT_I & wr_mask);

    // ************************************************************
    // register next value
    // ************************************************************
    always_comb begin
        cfg_d = cfg_q;
        if (wr_hit) begin
            cfg_d.gain = new_word[GAIN_LSB +: GAIN_W];
            cfg_d.offset_cancel = new_word[OFFS_BIT];
            cfg_d.spare = new_word[RSV_LSB +: RSV_W];
            cfg_d.neg = new_word[NEG_LSB +: NEG_W];
            cfg_d.pos = new_word[POS_LSB +: POS_W];
        end
    end

    // ************************************************************
    // gain decode
    // ************************************************************
    always_comb begin
        gain_d.gain_valid = 1'b1;
        case (cfg_d.gain)
            GAIN_X1: gain_d.gain_halves = HALVES_X1;
            GAIN_X1P5: gain_d.gain_halves = HALVES_X1P5;
            GAIN_X2: gain_d.gain_halves = HALVES_X2;
            GAIN_X4: gain_d.gain_halves = HALVES_X4;
            GAIN_X9A, GAIN_X9B: gain_d.gain_halves = HALVES_X9;
            default: begin
                // undefined codes fall back to unity gain
                gain_d.gain_halves = HALVES_X1;
                gain_d.gain_valid = 1'b0;
            end
        endcase
        // cancellation with the amplifier on is only calibrated at gain 4
        gain_d.gain_conflict = cfg_d.offset_cancel && AMP_ENABLE &&
            cfg_d.gain != GAIN_X4;
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            cfg_q <= '0;
            gain_q <= '{gain_halves: HALVES_X1, gain_valid: 1'b1,
                        gain_conflict: 1'b0};
            ack_q <= 1'b0;
            dat_q <= CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
            gain_q <= gain_d;
            ack_q <= req;
            if (req) begin
                // unmapped reads answer with zero rather than an error
                dat_q <= rd_hit ? cfg_word : 32'h0000_0000;
            end
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = dat_q;
    assign CFG = cfg_q;
    assign GAIN = gain_q;

    // ************************************************************
    // input multiplexer decoders
    // ************************************************************
    adc_sel_decode #(
        .W(NEG_W),
        .VALID(NEG_VALID)
    ) u_neg (
        .clk(CLK),
        .reset_n(RESET_N),
        .code(cfg_q.neg),
        .route_q(NEG_ROUTE),
        .reserved_q(NEG_RESERVED)
    );

    adc_sel_decode #(
        .W(POS_W),
        .VALID(POS_VALID)
    ) u_pos (
        .clk(CLK),
        .reset_n(RESET_N),
        .code(cfg_q.pos),
        .route_q(POS_ROUTE),
        .reserved_q(POS_RESERVED)
    );

    // ************************************************************
    // checks
    // ************************************************************
    a_reset_clears: assert property (@(posedge CLK)
        !RESET_N |=> CFG == '0 && !WB_ACK_O)
        else $error("register not cleared by reset");

    a_write_lands: assert property (@(posedge CLK) disable iff (!RESET_N)
        (wr_hit && WB_SEL_I == 4'hf) |=>
        CFG.gain == $past(WB_DAT_I[18:16]) &&
        CFG.offset_cancel == $past(WB_DAT_I[15]) &&
        CFG.neg == $past(WB_DAT_I[12:8]) &&
        CFG.pos == $past(WB_DAT_I[5:0]))
        else $error("full write did not land in fields");

    a_ack_single: assert property (@(posedge CLK) disable iff (!RESET_N)
        (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("ack not a single cycle after request");

    a_reserved_zero: assert property (@(posedge CLK)
        disable iff (!RESET_N)
        WB_ACK_O |-> WB_DAT_O[31:19] == '0 && WB_DAT_O[7:6] == '0)
        else $error("reserved bits read nonzero");

    a_unmapped_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
        (req && !hit) |=> WB_ACK_O && WB_DAT_O == 32'h0000_0000)
        else $error("unmapped access not answered with zero");

    a_gain_four: assert property (@(posedge CLK) disable iff (!RESET_N)
        (cfg_d.gain == GAIN_X4) |=> GAIN.gain_halves == 5'h08)
        else $error("gain code 3 not reported as gain 4");

    a_gain_nine: assert property (@(posedge CLK) disable iff (!RESET_N)
        (cfg_d.gain == GAIN_X9A || cfg_d.gain == GAIN_X9B) |=>
        GAIN.gain_halves == 5'h12)
        else $error("gain codes 4 and 5 not reported as gain 9");

    a_conflict_flag: assert property (@(posedge CLK) disable iff (!RESET_N)
        ##1 GAIN.gain_conflict == ($past(cfg_d.offset_cancel) &&
        $past(AMP_ENABLE) && $past(cfg_d.gain) != 3'h3))
        else $error("cancellation gain conflict flag wrong");

    a_cancel_held: assert property (@(posedge CLK) disable iff (!RESET_N)
        !wr_hit |=> $stable(CFG.offset_cancel))
        else $error("cancellation bit changed without a write");

    a_temp_route: assert property (@(posedge CLK) disable iff (!RESET_N)
        (CFG.neg == NEG_TEMP_SENSOR && $stable(CFG.neg)) |=>
        NEG_ROUTE == 32'h0000_0800)
        else $error("sensor negative output not routed");

    a_excite_route: assert property (@(posedge CLK) disable iff (!RESET_N)
        CFG.pos == POS_EXCITE |=> POS_ROUTE[36] && !POS_RESERVED)
        else $error("excitation node not routed");

    a_half_ce_route: assert property (@(posedge CLK) disable iff (!RESET_N)
        CFG.pos == POS_CE_HALF |=> POS_ROUTE[31])
        else $error("half counter electrode not routed");
endmodule

//--- tb_top.sv
// self-checking bench for the converter input configuration register
// assumes adc_cfg_pkg and adc_input_config; drives the wishbone port itself
`timescale 1ns/1ps
module tb_top;
    import adc_cfg_pkg::*;
    // ************************************************************
    // signals
    // ************************************************************
    logic clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, amp_en = 0;
    logic [ADR_W-1:0] adr = '0;
    logic [3:0] sel = '0;
    logic [31:0] dat_i = '0, dat_o, model = '0, rs = 32'h0000_005b;
    logic ack, neg_res, pos_res;
    logic [31:0] neg_route;
    logic [63:0] pos_route;
    cfg_s cfg;
    gain_s gain;
    logic [31:0] rd_q[$];
    int err_total = 0, checks_done = 0, cyc_cnt = 0;
    adc_input_config DUT (.CLK(clk), .RESET_N(reset_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
        .AMP_ENABLE(amp_en), .CFG(cfg), .GAIN(gain), .NEG_ROUTE(neg_route),
        .NEG_RESERVED(neg_res), .POS_ROUTE(pos_route),
        .POS_RESERVED(pos_res));
    initial begin
        forever #2 clk = ~clk;
    end
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one classic cycle; entered just after a rising edge
    task automatic bus(logic w, logic [15:0] a, logic [3:0] s,
                       logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat_i <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk("ack", 64'h1, 64'h0);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(logic [15:0] a, logic [3:0] s, logic [31:0] d);
        bus(1'b1, a, s, d);
        if (a[15:2] == CFG_ADDR[15:2]) begin
            for (int i = 0; i < 4; i++)
                if (s[i]) model[8*i +: 8] = d[8*i +: 8];
        end
        model = model & CFG_RW_MASK;
        repeat (3) @(posedge clk);
    endtask
    task automatic rd(logic [15:0] a, logic [31:0] e);
        rd_q.push_back(e);
        bus(1'b0, a, 4'hf, xs());
    endtask
    task automatic chk_cfg();
        chk("cfg", 64'({model[18:8], model[5:0]}), 64'(cfg));
    endtask
    // ************************************************************
    // read data monitor
    // ************************************************************
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0)
            chk("rdata", 64'(rd_q.pop_front()), 64'(dat_o));
    end
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            err_total++;
            end_sim();
        end
    end
    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        logic [31:0] d, r;
        logic [4:0] h;
        logic [5:0] c;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk_cfg();
        chk("gain", 64'h0a, 64'(gain));
        rd(CFG_ADDR, 32'h0);
        for (int i = 0; i < 24; i++) begin
            d = xs();
            r = xs();
            wr(r[0] ? CFG_ADDR | 16'(r[2:1]) : 16'h21ac, r[7:4], d);
            chk_cfg();
            rd(CFG_ADDR, model);
            rd(16'h21a4, 32'h0);
        end
        for (int g = 0; g < 8; g++) begin
            amp_en <= g[1];
            wr(CFG_ADDR, 4'hf, 32'(g) << GAIN_LSB | 32'h8000);
            case (g)
                0: h = HALVES_X1;
                1: h = HALVES_X1P5;
                2: h = HALVES_X2;
                3: h = HALVES_X4;
                4, 5: h = HALVES_X9;
                default: h = HALVES_X1;
            endcase
            chk("gain", 64'({h, g < 6, g[1] && g != 3}), 64'(gain));
        end
        for (int k = 0; k < 64; k++) begin
            c = 6'(k);
            wr(CFG_ADDR, 4'h3, {16'h0, 3'h0, c[4:0], 2'h0, c});
            r = (NEG_VALID[c[4:0]] && c[4:0] != 0) ? 32'h1 << c[4:0] : 0;
            chk("neg_route", 64'(r), 64'(neg_route));
            chk("neg_res", 64'(!NEG_VALID[c[4:0]]), 64'(neg_res));
            chk("pos_route", (POS_VALID[c] && c != 0) ? 64'h1 << c : 64'h0,
                pos_route);
            chk("pos_res", 64'(!POS_VALID[c]), 64'(pos_res));
        end
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        model = CFG_RESET;
        repeat (2) @(posedge clk);
        chk_cfg();
        chk("pos_route", 64'h0, pos_route);
        chk("gain", 64'h0a, 64'(gain));
        end_sim();
    end
endmodule
